// ---- rtl/pdm_ctrl.sv ----
// Operation
// - Sleep: core halted, peripherals and clocks run
// - Peripheral halt: peripherals stop, core runs
// - System stop: core, peripherals stop; 1.5-clock recovery, rounded up to two clocks
// - Idle: clock output stops, oscillator runs
// - Control bits six/three pick standby or idle
// - Enter only with halt bit plus sleep
// - Standby also stops oscillator and all clocks
// - Standby wake waits 2^17 stabilisation counts
// - Wake source drops early: back to standby
// - Reset restarts clocks, normal reset sequence
// - Bus request wakes only when enabled
// - Bus wake floats bus, asserts grant
// - Request withdrawn: bus reclaimed, standby left
// - Bus stays released while request persists
// - Non-maskable wake starts its acknowledge
// - Disabled maskable source never ends standby
// - Enabled source, global flag set: acknowledge
// - Global flag clear: continue after sleep
// - Non-maskable falling edge is latched
// - Idle exit skips counter, eight-clock delay
// - Quick standby waits only 2^6 clocks
`timescale 1ns/1ps
`default_nettype none
`include "pdm_map.svh"

module pdm_ctrl #(
  parameter int unsigned STAB_NORMAL = `PDM_STAB_NORMAL,
  parameter int unsigned STAB_QUICK = `PDM_STAB_QUICK,
  parameter int unsigned CNT_W = `PDM_CNT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_exec,
  input wire logic global_int_enable_flag,
  input wire logic nmi_in_n,
  input wire logic ext_int_zero_in_n,
  input wire logic ext_int_one_in_n,
  input wire logic ext_int_two_in_n,
  input wire logic bus_request_in_n,
  output logic cpu_halt,
  output logic periph_halt,
  output logic osc_enable,
  output logic system_clock_out_en,
  output logic bus_grant_out_n,
  output logic addr_ctrl_oe,
  output logic nmi_ack,
  output logic [2:0] int_ack,
  output logic resume_next,
  output pdm_pkg::pdm_state_e power_state
);
  import pdm_pkg::*;

  localparam int unsigned RECOV_CYC = (`PDM_RECOV_TENTHS + 9) / 10;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [4:0] pins_s;
  logic nmi_s;
  logic [2:0] int_act;
  logic breq_act;

  pdm_sync #(
    .W(5),
    .RST_VAL(5'h1F)
  ) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d_in({bus_request_in_n, ext_int_two_in_n, ext_int_one_in_n,
           ext_int_zero_in_n, nmi_in_n}),
    .q_out(pins_s)
  );

  // Active-high views of the interrupt and bus pins; nmi_s stays active-low
  assign nmi_s = pins_s[0];
  assign int_act = ~pins_s[3:1];
  assign breq_act = ~pins_s[4];

  // ----------------------------------------
  // Registers and APB slave
  // ----------------------------------------
  pdm_byte_t cpu_ctrl_ff;
  pdm_byte_t io_ctrl_ff;
  pdm_byte_t itc_ff;
  pdm_state_e state_ff;
  pdm_state_e nxt_state;
  logic [9:0] idx;
  logic acc_go;
  logic req_new;
  logic hit;
  logic [31:0] rdata;
  logic nmi_latch_ff;

  assign idx = paddr[11:2];
  assign req_new = psel & penable & ~pready;
  assign acc_go = psel & penable & pready;

  // Read mux; unmapped words read zero and flag an error
  always_comb begin
    hit = 1'b1;
    rdata = 32'h0;
    case (idx)
      `PDM_CPU_CTRL_IDX: rdata = {24'h0, cpu_ctrl_ff};
      `PDM_IO_CTRL_IDX: rdata = {24'h0, io_ctrl_ff};
      `PDM_INT_TRAP_IDX: rdata = {24'h0, itc_ff};
      `PDM_STATUS_IDX: rdata = {23'h0, nmi_latch_ff, state_ff};
      default: hit = 1'b0;
    endcase
  end

  // One wait state: pready rises one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= req_new;
      if (req_new) begin
        prdata <= pwrite ? 32'h0 : rdata;
        pslverr <= ~hit;
      end
    end
  end

  // Software writes land on the completing edge only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_ctrl_ff <= `PDM_CPU_CTRL_RST;
      io_ctrl_ff <= `PDM_IO_CTRL_RST;
      itc_ff <= `PDM_INT_TRAP_RST;
    end else if (acc_go && pwrite) begin
      case (idx)
        `PDM_CPU_CTRL_IDX: cpu_ctrl_ff <= pwdata[7:0];
        `PDM_IO_CTRL_IDX: io_ctrl_ff <= pwdata[7:0];
        `PDM_INT_TRAP_IDX: itc_ff <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  logic stby_sel;
  logic quick_sel;
  logic brwake_en;
  logic io_stop;

  assign stby_sel = cpu_ctrl_ff[`PDM_STBY_SEL_BIT];
  assign quick_sel = cpu_ctrl_ff[`PDM_QUICK_SEL_BIT];
  assign brwake_en = cpu_ctrl_ff[`PDM_BRWAKE_BIT];
  assign io_stop = io_ctrl_ff[`PDM_IO_STOP_BIT];

  // ----------------------------------------
  // Wake sources
  // ----------------------------------------
  logic nmi_prev_ff;
  logic nmi_fall;
  logic nmi_clr;
  logic [2:0] int_wake;
  logic breq_wake;
  logic irq_wake;
  logic deep_wake;

  assign nmi_fall = nmi_prev_ff & ~nmi_s;
  assign int_wake = int_act & itc_ff[`PDM_INT_EN_MSB:`PDM_INT_EN_LSB];
  assign breq_wake = breq_act & brwake_en;
  assign irq_wake = nmi_latch_ff | (|int_wake);
  assign deep_wake = irq_wake | breq_wake;

  // Edge latch keeps a short pulse alive; a new edge beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_prev_ff <= 1'b1;
      nmi_latch_ff <= 1'b0;
    end else begin
      nmi_prev_ff <= nmi_s;
      if (nmi_fall) begin
        nmi_latch_ff <= 1'b1;
      end else if (nmi_clr) begin
        nmi_latch_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Recovery counter
  // ----------------------------------------
  logic cnt_load;
  logic cnt_abort;
  logic cnt_done;
  logic [CNT_W-1:0] cnt_val;

  pdm_stab_cnt #(
    .W(CNT_W)
  ) u_cnt (
    .clk(pclk),
    .rst_n(presetn),
    .load(cnt_load),
    .abort(cnt_abort),
    .load_val(cnt_val),
    .done(cnt_done)
  );

  // ----------------------------------------
  // Power state machine
  // ----------------------------------------
  logic hold_ff;
  logic rec_done;
  logic bus_rel;

  assign rec_done = (state_ff == PDM_ST_RECOV) && cnt_done;
  assign nmi_clr = rec_done & nmi_latch_ff;

  // Next state and counter loads
  always_comb begin
    nxt_state = state_ff;
    cnt_load = 1'b0;
    cnt_abort = 1'b0;
    cnt_val = '0;
    case (state_ff)
      PDM_ST_RUN: begin
        // Already released: no further recovery loops while held
        if (hold_ff && breq_act && !bus_rel) begin
          nxt_state = PDM_ST_RECOV;
          cnt_load = 1'b1;
          cnt_val = CNT_W'(RECOV_CYC);
        end else if (sleep_exec && !io_stop) begin
          nxt_state = PDM_ST_SLEEP;
        end else if (sleep_exec) begin
          case ({stby_sel, quick_sel})
            2'b10: nxt_state = PDM_ST_STANDBY;
            2'b11: nxt_state = PDM_ST_STANDBY;
            2'b01: nxt_state = PDM_ST_IDLE;
            default: nxt_state = PDM_ST_SYSSTOP;
          endcase
        end
      end
      PDM_ST_SLEEP, PDM_ST_SYSSTOP: begin
        if (irq_wake) begin
          nxt_state = PDM_ST_RECOV;
          cnt_load = 1'b1;
          cnt_val = CNT_W'(RECOV_CYC);
        end
      end
      PDM_ST_IDLE: begin
        if (deep_wake) begin
          nxt_state = PDM_ST_IDLEWAIT;
          cnt_load = 1'b1;
          cnt_val = CNT_W'(`PDM_IDLE_DELAY);
        end
      end
      PDM_ST_STANDBY: begin
        if (deep_wake) begin
          nxt_state = PDM_ST_STAB;
          cnt_load = 1'b1;
          cnt_val = quick_sel ? CNT_W'(STAB_QUICK) : CNT_W'(STAB_NORMAL);
        end
      end
      PDM_ST_STAB: begin
        if (!deep_wake) begin
          nxt_state = PDM_ST_STANDBY;
          cnt_abort = 1'b1;
        end else if (cnt_done) begin
          nxt_state = PDM_ST_RECOV;
          cnt_load = 1'b1;
          cnt_val = CNT_W'(RECOV_CYC);
        end
      end
      PDM_ST_IDLEWAIT: begin
        if (cnt_done) begin
          nxt_state = PDM_ST_RECOV;
          cnt_load = 1'b1;
          cnt_val = CNT_W'(RECOV_CYC);
        end
      end
      PDM_ST_RECOV: begin
        if (cnt_done) begin
          nxt_state = PDM_ST_RUN;
        end
      end
      default: nxt_state = PDM_ST_RUN;
    endcase
  end

  // Reset leaves the state at run with clocks going
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= PDM_ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Bus hand-over pending after reset or a deep power-down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_ff <= 1'b1;
    end else if (nxt_state == PDM_ST_STANDBY
                 || nxt_state == PDM_ST_IDLE) begin
      hold_ff <= 1'b1;
    end else if (state_ff == PDM_ST_RUN && !breq_act) begin
      hold_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Clock, halt and bus outputs
  // ----------------------------------------
  logic nxt_bus_rel;

  // Released while a waking request persists, else on withdrawal
  assign nxt_bus_rel = bus_rel ? breq_act
                       : (rec_done && hold_ff && breq_act);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_rel <= 1'b0;
    end else begin
      bus_rel <= nxt_bus_rel;
    end
  end

  // Outputs follow the next state so they line up with state_ff
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_halt <= 1'b0;
      periph_halt <= 1'b0;
      osc_enable <= 1'b1;
      system_clock_out_en <= 1'b1;
      bus_grant_out_n <= 1'b1;
      addr_ctrl_oe <= 1'b1;
      power_state <= PDM_ST_RUN;
    end else begin
      cpu_halt <= (nxt_state != PDM_ST_RUN) || nxt_bus_rel;
      periph_halt <= (nxt_state == PDM_ST_RUN) ? io_stop
                     : (nxt_state != PDM_ST_SLEEP);
      osc_enable <= (nxt_state != PDM_ST_STANDBY);
      system_clock_out_en <= !(nxt_state == PDM_ST_IDLE
                              || nxt_state == PDM_ST_STANDBY
                              || nxt_state == PDM_ST_STAB
                              || nxt_state == PDM_ST_IDLEWAIT);
      bus_grant_out_n <= ~nxt_bus_rel;
      addr_ctrl_oe <= ~nxt_bus_rel;
      power_state <= nxt_state;
    end
  end

  // Acknowledge pulses at the end of recovery
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_ack <= 1'b0;
      int_ack <= 3'h0;
      resume_next <= 1'b0;
    end else begin
      nmi_ack <= nmi_clr;
      int_ack <= (rec_done && !nmi_latch_ff && global_int_enable_flag)
                 ? int_wake : 3'h0;
      resume_next <= rec_done && !nmi_latch_ff && (|int_wake)
                     && !global_int_enable_flag;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------

  // Cycles spent in stabilisation, only for the length checks
  logic [CNT_W-1:0] stab_cyc_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stab_cyc_ff <= '0;
    end else if (state_ff == PDM_ST_STAB) begin
      stab_cyc_ff <= stab_cyc_ff + CNT_W'(1);
    end else begin
      stab_cyc_ff <= '0;
    end
  end

  AST_STAB_NORMAL: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == PDM_ST_STAB && cnt_done && !quick_sel
      |-> stab_cyc_ff == CNT_W'(STAB_NORMAL - 1))
    else $error("normal stabilisation length wrong");
  AST_SLEEP_HALT: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == PDM_ST_SLEEP |-> cpu_halt && !periph_halt
      && osc_enable && system_clock_out_en)
    else $error("sleep outputs wrong");

  AST_IOSTOP_RUN: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == PDM_ST_RUN && $past(state_ff) == PDM_ST_RUN
      && !bus_rel |-> !cpu_halt && periph_halt == $past(io_stop))
    else $error("peripheral halt not following bit");

  AST_SYSSTOP_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == PDM_ST_SYSSTOP && irq_wake
      |=> state_ff == PDM_ST_RECOV [*2] ##1 state_ff == PDM_ST_RUN)
    else $error("system stop recovery not two cycles");

  AST_IDLE_CLOCKS: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == PDM_ST_IDLE |-> osc_enable && !system_clock_out_en
      && cpu_halt && periph_halt)
    else $error("idle clock gating wrong");

  AST_ENTER_SEL: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == PDM_ST_RUN && !(hold_ff && breq_act) && sleep_exec
      && io_stop && stby_sel && !quick_sel
      |=> state_ff == PDM_ST_STANDBY)
    else $error("standby not selected");

  AST_ENTER_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == PDM_ST_RUN && !sleep_exec
      |=> state_ff inside {PDM_ST_RUN, PDM_ST_RECOV})
    else $error("power-down entered without sleep");

  AST_STANDBY_OFF: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == PDM_ST_STANDBY |-> !osc_enable
      && !system_clock_out_en && cpu_halt && periph_halt)
    else $error("standby clocks not stopped");

  AST_STAB_ABORT: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == PDM_ST_STAB && !deep_wake
      |=> state_ff == PDM_ST_STANDBY)
    else $error("stabilisation not aborted");

  AST_BREQ_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == PDM_ST_STANDBY && !irq_wake && !brwake_en
      |=> state_ff == PDM_ST_STANDBY)
    else $error("disabled bus request woke standby");

  AST_BUS_GRANT: assert property (@(posedge pclk) disable iff (!presetn)
    bus_rel && breq_act |=> !bus_grant_out_n && !addr_ctrl_oe)
    else $error("bus not released");

  AST_NMI_LATCH: assert property (@(posedge pclk) disable iff (!presetn)
    nmi_fall |=> nmi_latch_ff)
    else $error("nmi edge not latched");

  AST_IDLE_DELAY: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state_ff == PDM_ST_IDLEWAIT)
      |-> (state_ff == PDM_ST_IDLEWAIT) [*8]
      ##1 state_ff == PDM_ST_RECOV)
    else $error("idle exit delay not eight");

  AST_QUICK_STAB: assert property (@(posedge pclk) disable iff (!presetn)
    state_ff == PDM_ST_STAB && cnt_done && quick_sel
      |-> stab_cyc_ff == CNT_W'(STAB_QUICK - 1))
    else $error("quick stabilisation length wrong");

  AST_NMI_ACK: assert property (@(posedge pclk) disable iff (!presetn)
    rec_done && nmi_latch_ff |=> nmi_ack && int_ack == 3'h0
      && !resume_next)
    else $error("nmi acknowledge missing");

endmodule

`default_nettype wire

// ---- rtl/pdm_map.svh ----
`ifndef PDM_MAP_SVH
`define PDM_MAP_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define PDM_CPU_CTRL_IDX 10'h01F
`define PDM_IO_CTRL_IDX 10'h03F
`define PDM_INT_TRAP_IDX 10'h034
`define PDM_STATUS_IDX 10'h040

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PDM_STBY_SEL_BIT 6
`define PDM_BRWAKE_BIT 5
`define PDM_QUICK_SEL_BIT 3
`define PDM_IO_STOP_BIT 5
`define PDM_INT_EN_LSB 0
`define PDM_INT_EN_MSB 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PDM_CPU_CTRL_RST 8'h00
`define PDM_IO_CTRL_RST 8'h00
`define PDM_INT_TRAP_RST 8'h00

// ----------------------------------------
// Timing, in system clocks (recovery in tenths of a clock), and counter width
// ----------------------------------------
`define PDM_STAB_NORMAL 131072
`define PDM_STAB_QUICK 64
`define PDM_IDLE_DELAY 8
`define PDM_RECOV_TENTHS 15
`define PDM_CNT_W 18

`endif

// ---- rtl/pdm_pkg.sv ----
`default_nettype none

package pdm_pkg;

  // Power states, one-hot
  typedef enum logic [7:0] {
    PDM_ST_RUN      = 8'h01,
    PDM_ST_SLEEP    = 8'h02,
    PDM_ST_SYSSTOP  = 8'h04,
    PDM_ST_IDLE     = 8'h08,
    PDM_ST_STANDBY  = 8'h10,
    PDM_ST_STAB     = 8'h20,
    PDM_ST_IDLEWAIT = 8'h40,
    PDM_ST_RECOV    = 8'h80
  } pdm_state_e;

  typedef logic [7:0] pdm_byte_t;

endpackage

`default_nettype wire

// ---- rtl/pdm_stab_cnt.sv ----
`timescale 1ns/1ps
`default_nettype none

module pdm_stab_cnt #(
  parameter int W = 18
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic abort,
  input wire logic [W-1:0] load_val,
  output logic done
);

  logic [W-1:0] cnt_ff;
  logic busy_ff;

  // Down counter; done marks the last counted cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      busy_ff <= 1'b0;
    end else if (abort) begin
      cnt_ff <= '0;
      busy_ff <= 1'b0;
    end else if (load) begin
      cnt_ff <= load_val;
      busy_ff <= 1'b1;
    end else if (busy_ff) begin
      cnt_ff <= cnt_ff - W'(1);
      if (cnt_ff == W'(1)) begin
        busy_ff <= 1'b0;
      end
    end
  end

  assign done = busy_ff & (cnt_ff == W'(1));

endmodule

`default_nettype wire

// ---- rtl/pdm_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module pdm_sync #(
  parameter int W = 5,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] meta_ff;

  // Two stages; only the second stage is read outside
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= RST_VAL;
      q_out <= RST_VAL;
    end else begin
      meta_ff <= d_in;
      q_out <= meta_ff;
    end
  end

endmodule

`default_nettype wire

// ---- testbench/pdm_far_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Interrupt sources and bus master
// ----------------------------------------
module pdm_far_model (
  input wire logic pclk,
  input wire logic [2:0] int_req,
  input wire logic nmi_req,
  input wire logic bus_req,
  input wire logic drop,
  input wire logic [2:0] int_ack,
  input wire logic resume_next,
  output logic nmi_in_n,
  output logic ext_int_zero_in_n,
  output logic ext_int_one_in_n,
  output logic ext_int_two_in_n,
  output logic bus_request_in_n
);
  logic [2:0] hold_ff = 3'h0;
  logic [1:0] nmi_cnt_ff = 2'h0;
  logic bus_n_ff = 1'h1;

  // Source stays low until served; drop is a deliberate early release
  always_ff @(posedge pclk) begin
    hold_ff <= (hold_ff | int_req) & ~int_ack
               & ~{3{resume_next | drop}};
  end

  // Short low pulse only, so the block must remember the edge
  always_ff @(posedge pclk) begin
    if (nmi_req) begin
      nmi_cnt_ff <= 2'h3;
    end else if (nmi_cnt_ff != 2'h0) begin
      nmi_cnt_ff <= nmi_cnt_ff - 2'h1;
    end
  end

  // Bus request level, held as long as the bench asks
  always_ff @(posedge pclk) begin
    bus_n_ff <= ~bus_req;
  end

  // Pins are pulled high when nobody asserts them
  assign nmi_in_n = (nmi_cnt_ff == 2'h0);
  assign ext_int_zero_in_n = ~hold_ff[0];
  assign ext_int_one_in_n = ~hold_ff[1];
  assign ext_int_two_in_n = ~hold_ff[2];
  assign bus_request_in_n = bus_n_ff;
endmodule

`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pdm_map.svh"

module tb_top;
  import pdm_pkg::*;
  localparam int NORM = 16;
  localparam int QUICK = 4;
  logic pclk, presetn, psel, penable, pwrite, sleep_exec, gflag;
  logic nmi_req, bus_req, drop, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] int_req, int_ack;
  logic cpu_halt, periph_halt, osc_enable, clk_en, grant_n, addr_oe;
  logic nmi_ack, resume_next, nmi_n, i0_n, i1_n, i2_n, breq_n;
  pdm_state_e power_state;
  int n_errors = 0;
  int samples_checked = 0;
  int n;

  pdm_ctrl #(.STAB_NORMAL(NORM), .STAB_QUICK(QUICK)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_exec(sleep_exec),
    .global_int_enable_flag(gflag), .nmi_in_n(nmi_n),
    .ext_int_zero_in_n(i0_n), .ext_int_one_in_n(i1_n),
    .ext_int_two_in_n(i2_n), .bus_request_in_n(breq_n),
    .cpu_halt(cpu_halt), .periph_halt(periph_halt),
    .osc_enable(osc_enable), .system_clock_out_en(clk_en),
    .bus_grant_out_n(grant_n), .addr_ctrl_oe(addr_oe),
    .nmi_ack(nmi_ack), .int_ack(int_ack), .resume_next(resume_next),
    .power_state(power_state));

  pdm_far_model far (
    .pclk(pclk), .int_req(int_req), .nmi_req(nmi_req), .bus_req(bus_req),
    .drop(drop), .int_ack(int_ack), .resume_next(resume_next),
    .nmi_in_n(nmi_n), .ext_int_zero_in_n(i0_n), .ext_int_one_in_n(i1_n),
    .ext_int_two_in_n(i2_n), .bus_request_in_n(breq_n));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  initial begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic hang();
    n_errors++;
    report_and_stop();
  endtask

  // One APB transfer; waits for pready, never a fixed count
  task automatic apb(input logic w, input logic [9:0] idx,
                     input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 20);
    if (k >= 20) hang();
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wait_st(input pdm_state_e s);
    int k;
    k = 0;
    do begin
      @(negedge pclk);
      k++;
    end while (power_state !== s && k < 400);
    if (power_state !== s) hang();
  endtask

  // Counts cycles spent in s, from the current negedge
  task automatic stay(input pdm_state_e s);
    n = 0;
    while (power_state === s && n < 400) begin
      n++;
      @(negedge pclk);
    end
  endtask

  task automatic till_grant(input logic v);
    int k;
    k = 0;
    while (grant_n !== v && k < 50) begin
      @(negedge pclk);
      k++;
    end
    if (grant_n !== v) hang();
  endtask

  // One-cycle request pulses to the far side
  task automatic kick(input logic [2:0] m, input logic nm, input logic dr);
    @(posedge pclk);
    int_req <= m;
    nmi_req <= nm;
    drop <= dr;
    @(posedge pclk);
    int_req <= 3'h0;
    nmi_req <= 1'h0;
    drop <= 1'h0;
  endtask

  // Program the three control bytes, then run the sleep instruction
  task automatic doze(input logic [7:0] cpu, input logic [7:0] io,
                      input logic [7:0] interrupt_trap_control, input logic f);
    apb(1'h1, `PDM_CPU_CTRL_IDX, {24'h0, cpu});
    apb(1'h1, `PDM_IO_CTRL_IDX, {24'h0, io});
    apb(1'h1, `PDM_INT_TRAP_IDX, {24'h0, interrupt_trap_control});
    gflag <= f;
    @(posedge pclk);
    sleep_exec <= 1'h1;
    @(posedge pclk);
    sleep_exec <= 1'h0;
  endtask

  function automatic logic [3:0] outs();
    return {cpu_halt, periph_halt, osc_enable, clk_en};
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    chk(outs(), 4'h3);
    apb(1'h1, `PDM_CPU_CTRL_IDX, 32'h68);
    apb(1'h0, `PDM_CPU_CTRL_IDX, 32'h0);
    chk(rd, 32'h68);
    apb(1'h0, 10'h3FE, 32'h0);
    chk(er, 1'h1);
    apb(1'h1, `PDM_STATUS_IDX, 32'hFF);
    apb(1'h0, `PDM_STATUS_IDX, 32'h0);
    chk(rd[7:0], PDM_ST_RUN);
  endtask

  task automatic t_sleep();
    doze(8'h40, 8'h00, 8'h02, 1'h1);
    wait_st(PDM_ST_SLEEP);
    chk(outs(), 4'hB);
    kick(3'h2, 1'h0, 1'h0);
    wait_st(PDM_ST_RECOV);
    stay(PDM_ST_RECOV);
    chk(int_ack, 3'h2);
  endtask

  task automatic t_sysstop();
    apb(1'h1, `PDM_CPU_CTRL_IDX, 32'h40);
    apb(1'h1, `PDM_IO_CTRL_IDX, 32'h20);
    // Halt output is registered one edge after the write lands
    repeat (2) @(negedge pclk);
    chk({cpu_halt, periph_halt}, 2'h1);
    chk(power_state, PDM_ST_RUN);
    doze(8'h00, 8'h20, 8'h01, 1'h1);
    wait_st(PDM_ST_SYSSTOP);
    chk(outs(), 4'hF);
    kick(3'h1, 1'h0, 1'h0);
    wait_st(PDM_ST_RECOV);
    stay(PDM_ST_RECOV);
    chk(n, 2);
    chk(int_ack, 3'h1);
  endtask

  task automatic t_idle();
    doze(8'h08, 8'h20, 8'h01, 1'h0);
    wait_st(PDM_ST_IDLE);
    chk(outs(), 4'hE);
    kick(3'h1, 1'h0, 1'h0);
    wait_st(PDM_ST_IDLEWAIT);
    stay(PDM_ST_IDLEWAIT);
    chk(n, 8);
    stay(PDM_ST_RECOV);
    chk({resume_next, int_ack}, 4'h8);
  endtask

  // Disabled source and disabled bus wake must leave standby alone
  task automatic t_stby(input logic [7:0] cpu, input int exp);
    doze(cpu, 8'h20, 8'h02, 1'h1);
    wait_st(PDM_ST_STANDBY);
    chk(outs(), 4'hC);
    @(posedge pclk);
    bus_req <= 1'h1;
    kick(3'h4, 1'h0, 1'h0);
    repeat (20) @(negedge pclk);
    chk(power_state, PDM_ST_STANDBY);
    @(posedge pclk);
    bus_req <= 1'h0;
    kick(3'h0, 1'h0, 1'h1);
    kick(3'h2, 1'h0, 1'h0);
    wait_st(PDM_ST_STAB);
    chk(osc_enable, 1'h1);
    stay(PDM_ST_STAB);
    chk(n, exp);
    stay(PDM_ST_RECOV);
    chk(int_ack, 3'h2);
  endtask

  task automatic t_drop();
    doze(8'h40, 8'h20, 8'h02, 1'h1);
    wait_st(PDM_ST_STANDBY);
    kick(3'h2, 1'h0, 1'h0);
    wait_st(PDM_ST_STAB);
    kick(3'h0, 1'h0, 1'h1);
    wait_st(PDM_ST_STANDBY);
    chk(osc_enable, 1'h0);
  endtask

  task automatic t_bus(input logic [7:0] cpu, input logic [2:0] m);
    doze(cpu, 8'h20, 8'h02, 1'h1);
    wait_st(PDM_ST_STANDBY);
    @(posedge pclk);
    bus_req <= 1'h1;
    kick(m, 1'h0, 1'h0);
    till_grant(1'h0);
    chk({addr_oe, cpu_halt}, 2'h1);
    repeat (10) @(negedge pclk);
    chk(grant_n, 1'h0);
    @(posedge pclk);
    bus_req <= 1'h0;
    till_grant(1'h1);
    chk(addr_oe, 1'h1);
    kick(3'h0, 1'h0, 1'h1);
    wait_st(PDM_ST_RUN);
  endtask

  task automatic t_nmi_rst();
    doze(8'h40, 8'h20, 8'h00, 1'h1);
    wait_st(PDM_ST_STANDBY);
    kick(3'h0, 1'h1, 1'h0);
    wait_st(PDM_ST_RECOV);
    stay(PDM_ST_RECOV);
    chk(nmi_ack, 1'h1);
    doze(8'h40, 8'h20, 8'h00, 1'h1);
    wait_st(PDM_ST_STANDBY);
    @(posedge pclk);
    presetn <= 1'h0;
    @(negedge pclk);
    chk({osc_enable, clk_en, power_state}, {2'h3, PDM_ST_RUN});
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, sleep_exec, gflag} = 6'h0;
    {nmi_req, bus_req, drop, int_req} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    @(negedge pclk);
    t_regs();
    t_sleep();
    t_sysstop();
    t_idle();
    t_stby(8'h40, NORM);
    t_stby(8'h48, QUICK);
    t_drop();
    t_bus(8'h60, 3'h0);
    t_bus(8'h40, 3'h2);
    t_nmi_rst();
    report_and_stop();
  end
endmodule

`default_nettype wire
